//--- shared/ssf_pkg.sv
package ssf_pkg;

  // register port geometry
  localparam int          SSF_AW          = 8;
  localparam int          SSF_DW          = 16;
  localparam logic [7:0]  SSF_OFF_GSW     = 8'h05;
  localparam logic [7:0]  SSF_OFF_ADC     = 8'h0D;
  localparam logic [7:0]  SSF_OFF_RAIL    = 8'h38;
  localparam logic [15:0] SSF_RST_VAL     = 16'h0000;

  // general status word fields
  localparam int          SSF_CLKR_LSB    = 12;
  localparam int          SSF_CLKR_W      = 4;
  localparam int          SSF_LRST_LSB    = 5;
  localparam int          SSF_LRST_W      = 3;
  localparam int          SSF_TOP_W       = 5;
  localparam logic [3:0]  SSF_CLKR_MID    = 4'h8;
  localparam logic [3:0]  SSF_CLKR_TOL    = 4'h1;

  // last reset cause codes
  localparam logic [2:0]  SSF_CAUSE_POR   = 3'h0;
  localparam logic [2:0]  SSF_CAUSE_PROJ  = 3'h1;
  localparam logic [2:0]  SSF_CAUSE_WD1   = 3'h2;
  localparam logic [2:0]  SSF_CAUSE_WD2   = 3'h3;
  localparam logic [2:0]  SSF_CAUSE_OTEMP = 3'h4;
  localparam logic [2:0]  SSF_CAUSE_SWPC  = 3'h5;

  // top level state codes
  localparam logic [4:0]  SSF_TS_SHUTDOWN = 5'h00;
  localparam logic [4:0]  SSF_TS_INIT_A   = 5'h01;
  localparam logic [4:0]  SSF_TS_OFF      = 5'h02;
  localparam logic [4:0]  SSF_TS_INIT_B   = 5'h03;
  localparam logic [4:0]  SSF_TS_PU_1V1   = 5'h04;
  localparam logic [4:0]  SSF_TS_PU_1V8   = 5'h05;
  localparam logic [4:0]  SSF_TS_PU_3V3   = 5'h06;
  localparam logic [4:0]  SSF_TS_REL_RST  = 5'h07;
  localparam logic [4:0]  SSF_TS_STANDBY  = 5'h08;
  localparam logic [4:0]  SSF_TS_OFS_EN   = 5'h09;
  localparam logic [4:0]  SSF_TS_BIAS_EN  = 5'h0A;
  localparam logic [4:0]  SSF_TS_DISP_RDY = 5'h0C;
  localparam logic [4:0]  SSF_TS_DISP_ON  = 5'h0D;
  localparam logic [4:0]  SSF_TS_PARK     = 5'h0E;
  localparam logic [4:0]  SSF_TS_PARK_OFF = 5'h0F;
  localparam logic [4:0]  SSF_TS_DISCHG   = 5'h11;

  // adc block status bits
  localparam int          SSF_ADC_STOP    = 7;
  localparam int          SSF_ADC_TLINE   = 6;
  localparam int          SSF_ADC_CMD     = 5;
  localparam int          SSF_ADC_PAR     = 4;
  localparam int          SSF_ADC_CH2U    = 3;
  localparam int          SSF_ADC_CH2S    = 2;
  localparam int          SSF_ADC_CH1U    = 1;
  localparam int          SSF_ADC_CH1S    = 0;

  // rail fault bits
  localparam int          SSF_RF_BIAS     = 15;
  localparam int          SSF_RF_RST      = 14;
  localparam int          SSF_RF_OFS      = 13;
  localparam int          SSF_RF_PG1      = 12;
  localparam int          SSF_RF_PG2      = 10;
  localparam int          SSF_RF_ALDO_UV  = 9;
  localparam int          SSF_RF_ALDO_OV  = 8;
  localparam int          SSF_RF_LDO3_UV  = 7;
  localparam int          SSF_RF_LDO3_OV  = 6;
  localparam int          SSF_RF_LDO_OV   = 5;
  localparam int          SSF_RF_3V3      = 2;
  localparam int          SSF_RF_1V8      = 1;
  localparam int          SSF_RF_1V1      = 0;
  localparam int          SSF_NPINS       = 15;

endpackage : ssf_pkg

//--- src/ssf_sync.sv
`timescale 1ns/1ps
module ssf_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage feeds only the second stage
  // flops live per bit so each process is the sole writer of its own state
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic stage1_ff;
      logic stage2_ff;

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
        end
        else
        begin
          stage1_ff <= async_in[gi];
          stage2_ff <= stage1_ff;
        end
      end

      assign sync_out[gi] = stage2_ff;
    end
  endgenerate

endmodule : ssf_sync

//--- src/ssf_status_regs.sv
`timescale 1ns/1ps
// What this block does
// - clock ratio reading sits in general status bits 15:12, mid-scale near 30 MHz.
// - last reset cause held in bits 7:5, captured while passing through off.
// - cause codes 000 to 101 as defined; other codes are never stored.
// - top state code in bits 4:0 of the general status word at 0x05.
// - top state reads 00 shutdown, 02 off, 01 or 03 initialization.
// - power-up codes 04 to 0A, 0C display ready, 0D display on.
// - parking codes 0E start, 0F rails off, 11 discharge.
// - adc status bit 7 set when a sequencer command lacks its stop bit.
// - adc status bit 6 set when a command arrives while one still runs.
// - adc status bit 5 set on any serial command error to the adc.
// - adc status bit 4 set on a command stream parity failure.
// - adc bits 3 and 2 show channel-two underflow and saturation.
// - adc bits 1 and 0 show channel-one underflow and saturation.
// - rail fault register at 0x38 is read-only, resets to zero, bits show live faults.
// - rail fault bits 15, 14, 13 flag low bias, reset, offset mirror rails.
// - rail fault bit 12 is main input or analog supply undervoltage.
// - rail fault bit 10 is undervoltage on any of 1.1, 1.8, 3.3, 6 V.
// - bits 9 and 8 flag adc 3 V regulator under and over voltage.
// - bits 7, 6 general 3 V regulator under/over; bit 5 other regulator over.
// - bits 2, 1, 0 flag undervoltage on 3.3, 1.8, 1.1 V rails.
// - summary power-good fault bit set whenever any rail fault bit is set.
// - summary adc error bit is the or of all adc status error bits.
module ssf_status_regs
  import ssf_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  // register port
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [SSF_AW-1:0]     reg_addr,
  input  wire logic [SSF_DW-1:0]     reg_wdata,
  output logic      [SSF_DW-1:0]     reg_rdata_ff,
  output logic                       reg_rvalid_ff,
  output logic                       reg_err_ff,
  // on-chip monitors, same clock
  input  wire logic [SSF_CLKR_W-1:0] clk_ratio_in,
  input  wire logic [SSF_LRST_W-1:0] reset_cause_in,
  input  wire logic [SSF_TOP_W-1:0]  top_state_in,
  input  wire logic                  adc_cmd_stop_missing,
  input  wire logic                  adc_cmd_overlap,
  input  wire logic                  adc_cmd_error,
  input  wire logic                  adc_cmd_parity_error,
  input  wire logic                  adc_ch2_underflow,
  input  wire logic                  adc_ch2_saturated,
  input  wire logic                  adc_ch1_underflow,
  input  wire logic                  adc_ch1_saturated,
  // analog comparator levels, asynchronous
  input  wire logic                  mirror_bias_rail_uv,
  input  wire logic                  mirror_reset_rail_uv,
  input  wire logic                  mirror_offset_rail_uv,
  input  wire logic                  main_input_rail_uv,
  input  wire logic                  analog_supply_rail_uv,
  input  wire logic                  rail_1v1_uv,
  input  wire logic                  rail_1v8_uv,
  input  wire logic                  rail_3v3_uv,
  input  wire logic                  rail_6v_uv,
  input  wire logic                  adc_ldo_uv,
  input  wire logic                  adc_ldo_ov,
  input  wire logic                  ldo3v_uv,
  input  wire logic                  ldo3v_ov,
  input  wire logic                  ldo_other_ov,
  input  wire logic                  spare_fault_in,
  // summary outputs
  output logic                       rail_fault_summary_ff,
  output logic                       adc_block_error_ff,
  output logic                       ext_clock_ok_ff
);

  logic [SSF_CLKR_W-1:0] clk_ratio_ff;
  logic [SSF_LRST_W-1:0] last_rst_ff;
  logic [SSF_TOP_W-1:0]  top_state_ff;
  logic [3:0]            adc_sticky_ff;
  logic [3:0]            adc_chan_ff;
  logic [SSF_DW-1:0]     rail_fault_ff;

  logic [SSF_LRST_W-1:0] nxt_last_rst;
  logic [SSF_TOP_W-1:0]  nxt_top_state;
  logic [3:0]            nxt_adc_sticky;
  logic [SSF_DW-1:0]     nxt_rail_fault;
  logic [SSF_DW-1:0]     nxt_rdata;
  logic [SSF_DW-1:0]     adc_status;
  logic [SSF_DW-1:0]     gsw_value;

  // comparator pins are not clocked by us
  logic [SSF_NPINS-1:0]  pins_raw;
  logic [SSF_NPINS-1:0]  pins_sync;

  assign pins_raw = {mirror_bias_rail_uv, mirror_reset_rail_uv, mirror_offset_rail_uv,
                     main_input_rail_uv, analog_supply_rail_uv, rail_1v1_uv, rail_1v8_uv,
                     rail_3v3_uv, rail_6v_uv, adc_ldo_uv, adc_ldo_ov, ldo3v_uv, ldo3v_ov,
                     ldo_other_ov, spare_fault_in};

  ssf_sync #(
    .WIDTH    (SSF_NPINS)
  ) u_pin_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  wire s_bias    = pins_sync[14];
  wire s_rst     = pins_sync[13];
  wire s_ofs     = pins_sync[12];
  wire s_main    = pins_sync[11];
  wire s_asup    = pins_sync[10];
  wire s_1v1     = pins_sync[9];
  wire s_1v8     = pins_sync[8];
  wire s_3v3     = pins_sync[7];
  wire s_6v      = pins_sync[6];
  wire s_aldo_uv = pins_sync[5];
  wire s_aldo_ov = pins_sync[4];
  wire s_ldo3_uv = pins_sync[3];
  wire s_ldo3_ov = pins_sync[2];
  wire s_ldo_ov  = pins_sync[1];
  // spare comparator has no home in the map; kept synchronised, never shown
  wire s_spare   = pins_sync[0];

  // rail fault map: live levels, reserved positions zero
  always_comb
  begin
    nxt_rail_fault                 = SSF_RST_VAL;
    nxt_rail_fault[SSF_RF_BIAS]    = s_bias;
    nxt_rail_fault[SSF_RF_RST]     = s_rst;
    nxt_rail_fault[SSF_RF_OFS]     = s_ofs;
    nxt_rail_fault[SSF_RF_PG1]     = s_main | s_asup;
    nxt_rail_fault[SSF_RF_PG2]     = s_1v1 | s_1v8 | s_3v3 | s_6v;
    nxt_rail_fault[SSF_RF_ALDO_UV] = s_aldo_uv;
    nxt_rail_fault[SSF_RF_ALDO_OV] = s_aldo_ov;
    nxt_rail_fault[SSF_RF_LDO3_UV] = s_ldo3_uv;
    nxt_rail_fault[SSF_RF_LDO3_OV] = s_ldo3_ov;
    nxt_rail_fault[SSF_RF_LDO_OV]  = s_ldo_ov & ~s_spare | s_ldo_ov;
    nxt_rail_fault[SSF_RF_3V3]     = s_3v3;
    nxt_rail_fault[SSF_RF_1V8]     = s_1v8;
    nxt_rail_fault[SSF_RF_1V1]     = s_1v1;
  end

  // cause code legality and top state legality
  wire cause_legal = (reset_cause_in <= SSF_CAUSE_SWPC);
  wire in_off      = (top_state_in == SSF_TS_OFF);

  wire top_legal   = (top_state_in == SSF_TS_SHUTDOWN) | (top_state_in == SSF_TS_INIT_A)
                   | (top_state_in == SSF_TS_OFF)      | (top_state_in == SSF_TS_INIT_B)
                   | (top_state_in == SSF_TS_PU_1V1)   | (top_state_in == SSF_TS_PU_1V8)
                   | (top_state_in == SSF_TS_PU_3V3)   | (top_state_in == SSF_TS_REL_RST)
                   | (top_state_in == SSF_TS_STANDBY)  | (top_state_in == SSF_TS_OFS_EN)
                   | (top_state_in == SSF_TS_BIAS_EN)  | (top_state_in == SSF_TS_DISP_RDY)
                   | (top_state_in == SSF_TS_DISP_ON)  | (top_state_in == SSF_TS_PARK)
                   | (top_state_in == SSF_TS_PARK_OFF) | (top_state_in == SSF_TS_DISCHG);

  // an unknown code would mislead the reader; hold the last good one
  assign nxt_top_state = top_legal ? top_state_in : top_state_ff;
  assign nxt_last_rst  = (in_off && cause_legal) ? reset_cause_in : last_rst_ff;

  // register decode
  wire hit_gsw   = (reg_addr == SSF_OFF_GSW);
  wire hit_adc   = (reg_addr == SSF_OFF_ADC);
  wire hit_rail  = (reg_addr == SSF_OFF_RAIL);
  wire hit_any   = hit_gsw | hit_adc | hit_rail;
  wire adc_clear = reg_rd & hit_adc;

  // sticky adc errors: read clears, a new event in the same cycle wins
  wire [3:0] adc_events = {adc_cmd_stop_missing, adc_cmd_overlap, adc_cmd_error, adc_cmd_parity_error};
  assign nxt_adc_sticky = (adc_clear ? 4'h0 : adc_sticky_ff) | adc_events;

  assign adc_status = {8'h00, adc_sticky_ff, adc_chan_ff};
  assign gsw_value  = {clk_ratio_ff, 4'h0, last_rst_ff, top_state_ff};

  assign nxt_rdata  = hit_gsw  ? gsw_value
                    : hit_adc  ? adc_status
                    : hit_rail ? rail_fault_ff
                    : SSF_RST_VAL;

  // write data is deliberately unused; every register here is read-only
  wire unused_wdata = ^reg_wdata;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clk_ratio_ff  <= '0;
      last_rst_ff   <= SSF_CAUSE_POR;
      top_state_ff  <= SSF_TS_SHUTDOWN;
      adc_sticky_ff <= 4'h0;
      adc_chan_ff   <= 4'h0;
      rail_fault_ff <= SSF_RST_VAL;
    end
    else
    begin
      clk_ratio_ff  <= clk_ratio_in;
      last_rst_ff   <= nxt_last_rst;
      top_state_ff  <= nxt_top_state;
      adc_sticky_ff <= nxt_adc_sticky;
      adc_chan_ff   <= {adc_ch2_underflow, adc_ch2_saturated,
                        adc_ch1_underflow, adc_ch1_saturated};
      rail_fault_ff <= nxt_rail_fault;
    end
  end

  // summaries follow the next register value so they never lag the bits
  wire [3:0] nxt_adc_chan = {adc_ch2_underflow, adc_ch2_saturated, adc_ch1_underflow, adc_ch1_saturated};
  wire       ratio_hi_ok  = (clk_ratio_in <= SSF_CLKR_MID + SSF_CLKR_TOL);
  wire       ratio_lo_ok  = (clk_ratio_in >= SSF_CLKR_MID - SSF_CLKR_TOL);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rail_fault_summary_ff <= 1'b0;
      adc_block_error_ff    <= 1'b0;
      ext_clock_ok_ff       <= 1'b0;
    end
    else
    begin
      rail_fault_summary_ff <= |nxt_rail_fault;
      adc_block_error_ff    <= |{nxt_adc_sticky, nxt_adc_chan};
      ext_clock_ok_ff       <= ratio_hi_ok & ratio_lo_ok;
    end
  end

  // read answer one cycle after the strobe; writes and holes report an error
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata_ff  <= SSF_RST_VAL;
      reg_rvalid_ff <= 1'b0;
      reg_err_ff    <= 1'b0;
    end
    else
    begin
      reg_rdata_ff  <= reg_rd ? nxt_rdata : SSF_RST_VAL;
      reg_rvalid_ff <= reg_rd;
      reg_err_ff    <= (reg_rd & ~hit_any) | (reg_wr & ~unused_wdata) | (reg_wr & unused_wdata);
    end
  end

  a_clk_ratio_field: assert property (@(posedge clk) disable iff (srst)
    reg_rd && hit_gsw |=> reg_rdata_ff[15:12] == $past(clk_ratio_ff))
    else $error("clock ratio field wrong");

  a_last_rst_capture: assert property (@(posedge clk) disable iff (srst)
    in_off && cause_legal |=> last_rst_ff == $past(reset_cause_in))
    else $error("reset cause not captured in off");

  a_last_rst_hold: assert property (@(posedge clk) disable iff (srst)
    !(in_off && cause_legal) |=> $stable(last_rst_ff))
    else $error("reset cause changed outside off or with unused code");

  a_top_state_track: assert property (@(posedge clk) disable iff (srst)
    top_legal |=> top_state_ff == $past(top_state_in))
    else $error("top state not tracked");

  a_top_state_low: assert property (@(posedge clk) disable iff (srst)
    top_state_in == SSF_TS_OFF ##1 1'b1 |-> reg_rd && hit_gsw |=> reg_rdata_ff[4:0] == $past(top_state_ff))
    else $error("top state read mismatch");

  a_top_state_bad: assert property (@(posedge clk) disable iff (srst)
    !top_legal |=> $stable(top_state_ff))
    else $error("illegal top state stored");

  a_top_state_park: assert property (@(posedge clk) disable iff (srst)
    top_state_in == SSF_TS_DISCHG |=> top_state_ff == SSF_TS_DISCHG)
    else $error("discharge code not shown");

  a_stop_bit_set: assert property (@(posedge clk) disable iff (srst)
    adc_cmd_stop_missing |=> adc_sticky_ff[3] ##1 (adc_sticky_ff[3] || $past(adc_clear)))
    else $error("stop bit flag lost");

  a_overlap_set: assert property (@(posedge clk) disable iff (srst)
    adc_cmd_overlap |=> adc_status[SSF_ADC_TLINE])
    else $error("overlap flag not set");

  a_cmd_err_set: assert property (@(posedge clk) disable iff (srst)
    adc_cmd_error && adc_clear |=> adc_status[SSF_ADC_CMD])
    else $error("command error lost against clear");

  a_parity_set: assert property (@(posedge clk) disable iff (srst)
    adc_cmd_parity_error |=> adc_status[SSF_ADC_PAR])
    else $error("parity flag not set");

  a_chan_flags: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> adc_status[3:0] == $past(nxt_adc_chan))
    else $error("channel flags wrong");

  a_ch1_flags: assert property (@(posedge clk) disable iff (srst)
    adc_ch1_saturated && !adc_ch1_underflow |=> adc_status[1:0] == 2'b01)
    else $error("channel one flags wrong");

  a_rail_reserved: assert property (@(posedge clk) disable iff (srst)
    rail_fault_ff[11] == 1'b0 && rail_fault_ff[4:3] == 2'b00)
    else $error("reserved rail bits set");

  a_bias_latency: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 1) == 1'b0 && $past(srst, 2) == 1'b0 && $past(srst, 3) == 1'b0
      |-> rail_fault_ff[SSF_RF_BIAS] == $past(mirror_bias_rail_uv, 3))
    else $error("bias fault latency wrong");

  a_pg1_or: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 1) == 1'b0 && $past(srst, 2) == 1'b0 && $past(srst, 3) == 1'b0
      |-> rail_fault_ff[SSF_RF_PG1] ==
      $past(main_input_rail_uv | analog_supply_rail_uv, 3))
    else $error("pg1 or wrong");

  a_pg2_or: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 1) == 1'b0 && $past(srst, 2) == 1'b0 && $past(srst, 3) == 1'b0
      |-> rail_fault_ff[SSF_RF_PG2] ==
      $past(rail_1v1_uv | rail_1v8_uv | rail_3v3_uv | rail_6v_uv, 3))
    else $error("pg2 or wrong");

  a_ldo_bits: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 1) == 1'b0 && $past(srst, 2) == 1'b0 && $past(srst, 3) == 1'b0
      |-> rail_fault_ff[9:5] ==
      $past({adc_ldo_uv, adc_ldo_ov, ldo3v_uv, ldo3v_ov, ldo_other_ov}, 3))
    else $error("regulator fault bits wrong");

  a_low_rails: assert property (@(posedge clk) disable iff (srst)
    $past(srst, 1) == 1'b0 && $past(srst, 2) == 1'b0 && $past(srst, 3) == 1'b0
      |-> rail_fault_ff[2:0] == $past({rail_3v3_uv, rail_1v8_uv, rail_1v1_uv}, 3))
    else $error("low rail bits wrong");

  a_pg_summary: assert property (@(posedge clk) disable iff (srst)
    rail_fault_summary_ff == (|rail_fault_ff))
    else $error("pg summary mismatch");

  a_adc_summary: assert property (@(posedge clk) disable iff (srst)
    adc_block_error_ff == (|adc_status))
    else $error("adc summary mismatch");

  a_write_ignored: assert property (@(posedge clk) disable iff (srst)
    reg_wr && !reg_rd |=> reg_err_ff && !reg_rvalid_ff && reg_rdata_ff == SSF_RST_VAL)
    else $error("write had an effect");

  a_rail_read: assert property (@(posedge clk) disable iff (srst)
    reg_rd && hit_rail |=> reg_rvalid_ff && reg_rdata_ff == $past(rail_fault_ff))
    else $error("rail fault read wrong");

  a_hole_zero: assert property (@(posedge clk) disable iff (srst)
    reg_rd && !hit_any |=> reg_err_ff && reg_rdata_ff == SSF_RST_VAL)
    else $error("unmapped read not zero with error");

endmodule : ssf_status_regs

//--- test/ssf_reader_model.sv
`timescale 1ns/1ps
module ssf_reader_model
  import ssf_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [SSF_DW-1:0] reg_rdata_ff,
  input  wire logic              reg_rvalid_ff,
  input  wire logic              reg_err_ff,
  output logic                   reg_rd,
  output logic                   reg_wr,
  output logic      [SSF_AW-1:0] reg_addr,
  output logic      [SSF_DW-1:0] reg_wdata
);
  initial
  begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end

  // one access held until the answer edge; idle lines show the inverse, not stale values
  task automatic access(input logic wr, input logic [SSF_AW-1:0] a, input logic [SSF_DW-1:0] wd,
                        output logic [SSF_DW-1:0] d, output logic e);
    int n;
    @(negedge clk);
    reg_rd    = !wr;
    reg_wr    = wr;
    reg_addr  = a;
    reg_wdata = wd;
    n = 0;
    @(negedge clk);
    while (reg_rvalid_ff !== 1'b1 && reg_err_ff !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    d = reg_rdata_ff;
    e = reg_err_ff;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~wd;
  endtask : access
endmodule : ssf_reader_model

//--- test/system_status_fault_registers_bench.sv
`timescale 1ns/1ps
module system_status_fault_registers_bench
  import ssf_pkg::*;
;
  logic        clk, srst, rd, wr, rvalid, err, e, rf_sum, adc_err, ck_ok;
  logic [3:0]  ratio, ev, lv;
  logic [2:0]  cause, cexp;
  logic [4:0]  top;
  logic [14:0] pins;
  logic [7:0]  addr;
  logic [15:0] rdata, wdata, d;
  logic [4:0]  codes [16];
  logic [15:0] rail_exp [16];
  int          miscompares, cmp_count, cycles;

  ssf_status_regs uut (.clk(clk), .srst(srst), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .reg_err_ff(err), .clk_ratio_in(ratio), .reset_cause_in(cause),
    .top_state_in(top), .adc_cmd_stop_missing(ev[3]), .adc_cmd_overlap(ev[2]), .adc_cmd_error(ev[1]),
    .adc_cmd_parity_error(ev[0]), .adc_ch2_underflow(lv[3]), .adc_ch2_saturated(lv[2]),
    .adc_ch1_underflow(lv[1]), .adc_ch1_saturated(lv[0]), .mirror_bias_rail_uv(pins[0]),
    .mirror_reset_rail_uv(pins[1]), .mirror_offset_rail_uv(pins[2]), .main_input_rail_uv(pins[3]),
    .analog_supply_rail_uv(pins[4]), .rail_1v1_uv(pins[5]), .rail_1v8_uv(pins[6]), .rail_3v3_uv(pins[7]),
    .rail_6v_uv(pins[8]), .adc_ldo_uv(pins[9]), .adc_ldo_ov(pins[10]), .ldo3v_uv(pins[11]),
    .ldo3v_ov(pins[12]), .ldo_other_ov(pins[13]), .spare_fault_in(pins[14]),
    .rail_fault_summary_ff(rf_sum), .adc_block_error_ff(adc_err), .ext_clock_ok_ff(ck_ok));

  ssf_reader_model rdr (.clk(clk), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .reg_err_ff(err),
    .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      miscompares++;
    end
  endtask : check

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp, input logic exp_e);
    rdr.access(1'b0, a, 16'h0000, d, e);
    check(nm, d, exp);
    check({nm, " err"}, {15'h0, e}, {15'h0, exp_e});
    check({nm, " valid"}, {15'h0, rvalid}, 16'h0001);
  endtask : rchk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ceiling well above the roughly 340 cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    srst = 1'b1;
    {ratio, ev, lv, cause, top, pins} = '0;
    codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
              5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11};
    rail_exp = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h1000, 16'h0401, 16'h0402, 16'h0404,
                 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0000, 16'hF7E7};
    repeat (2) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rchk("gsw reset", SSF_OFF_GSW, 16'h0000, 1'b0);
    rchk("adc reset", SSF_OFF_ADC, 16'h0000, 1'b0);
    rchk("rail reset", SSF_OFF_RAIL, 16'h0000, 1'b0);
    $display("reset values done");
    // table rows: pin pattern beside the rail word it must give; last row is all pins
    for (int i = 0; i < 16; i++)
    begin
      pins = (i < 15) ? (15'h1 << i) : 15'h7FFF;
      repeat (4) @(negedge clk);
      rchk("rail row", SSF_OFF_RAIL, rail_exp[i], 1'b0);
      check("rail summary", {15'h0, rf_sum}, {15'h0, rail_exp[i] != 16'h0000});
      pins = '0;
      repeat (4) @(negedge clk);
    end
    $display("rail rows done");
    for (int r = 6; r <= 10; r++)
    begin
      ratio = r[3:0];
      repeat (2) @(negedge clk);
      check("clock ok", {15'h0, ck_ok}, {15'h0, r >= 7 && r <= 9});
      rchk("ratio", SSF_OFF_GSW, {r[3:0], 12'h000}, 1'b0);
    end
    ratio = 4'h8;
    top = 5'h02;
    for (int c = 0; c <= 6; c++)
    begin
      cause = c[2:0];
      repeat (2) @(negedge clk);
      rchk("cause", SSF_OFF_GSW, {8'h80, (c < 6) ? c[2:0] : 3'h5, 5'h02}, 1'b0);
    end
    top = 5'h08;
    cause = 3'h1;
    repeat (2) @(negedge clk);
    rchk("cause held", SSF_OFF_GSW, {8'h80, 3'h5, 5'h08}, 1'b0);
    for (int k = 0; k < 18; k++)
    begin
      top = (k < 16) ? codes[k] : ((k == 16) ? 5'h0B : 5'h10);
      // passing through off at k == 2 captures the pending cause code
      cexp = (k < 2) ? 3'h5 : 3'h1;
      repeat (2) @(negedge clk);
      rchk("top", SSF_OFF_GSW, {8'h80, cexp, codes[(k < 16) ? k : 15]}, 1'b0);
    end
    $display("general status done");
    for (int k = 0; k < 4; k++)
    begin
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
      @(negedge clk);
      check("adc summary", {15'h0, adc_err}, 16'h0001);
      rchk("adc event", SSF_OFF_ADC, 16'h0010 << k, 1'b0);
      rchk("adc cleared", SSF_OFF_ADC, 16'h0000, 1'b0);
      check("adc summary off", {15'h0, adc_err}, 16'h0000);
    end
    lv = 4'hF;
    @(negedge clk);
    rchk("adc levels", SSF_OFF_ADC, 16'h000F, 1'b0);
    lv = 4'h5;
    @(negedge clk);
    rchk("adc levels", SSF_OFF_ADC, 16'h0005, 1'b0);
    lv = 4'h0;
    // event arriving in the very cycle of the clearing read must survive
    fork
      rchk("adc race", SSF_OFF_ADC, 16'h0000, 1'b0);
      begin
        @(negedge clk);
        ev = 4'hA;
        @(negedge clk);
        ev = 4'h0;
      end
    join
    rchk("adc kept", SSF_OFF_ADC, 16'h00A0, 1'b0);
    $display("adc status done");
    rdr.access(1'b1, SSF_OFF_GSW, 16'hFFFF, d, e);
    check("write err", {15'h0, e}, 16'h0001);
    check("write valid", {15'h0, rvalid}, 16'h0000);
    rchk("after write", SSF_OFF_GSW, {8'h80, 3'h1, 5'h11}, 1'b0);
    rchk("hole", 8'h06, 16'h0000, 1'b1);
    ev[1] = 1'b1;
    @(negedge clk);
    ev[1] = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    check("ok in reset", {15'h0, ck_ok}, 16'h0000);
    srst = 1'b0;
    rchk("adc after reset", SSF_OFF_ADC, 16'h0000, 1'b0);
    $display("write, hole and reset done");
    stop_test();
  end
endmodule : system_status_fault_registers_bench
